// *** rtl/idle_frame_rate_control.sv ***
// Idle-mode frame-rate control: command decoder and line/frame timer.
// Assumes the MCU pins are asynchronous and the mode and porch inputs
// come from logic on mclk.
// Notes on behaviour
// - Command B2h written with select low decodes.
// - Idle divider only under idle MCU; resets zero.
// - Divider 00 undivided, 01 halves the clock.
// - Clocks per idle line from five-bit field.
// - Line period field sets idle line length.
// - Base clock is oscillator divided by 26.
// - Frame equals line clocks times ratio times lines.
// - Selected division ratio multiplies frame period.
// - Driven lines plus both porches form frame.
module idle_frame_rate_control
	import idle_frame_rate_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               ce,
	// MCU write interface pins.
	input  wire logic               data_command_select,
	input  wire logic               read_strobe_n,
	input  wire logic               write_strobe_n,
	input  wire logic [7:0]         mcu_data,
	// Display mode and panel geometry.
	input  wire logic               idle_mode,
	input  wire logic               mcu_mode,
	input  wire logic [RTN_W-1:0]   normal_line_period,
	input  wire logic [LINE_W-1:0]  driven_lines,
	input  wire logic [PORCH_W-1:0] back_porch,
	input  wire logic [PORCH_W-1:0] front_porch,
	// Settings and timing outputs.
	output logic [DIV_W-1:0]        idle_clock_divider,
	output logic [RTN_W-1:0]        idle_line_period,
	output logic                    line_pulse,
	output logic                    frame_pulse,
	output logic [TOTAL_W-1:0]      line_index
);
	// Pin synchronisers: first stage, second stage, edge history.
	logic       dcx_s1, dcx_s2;       // Data/command select.
	logic       rd_s1, rd_s2;         // Read strobe, active low.
	logic       wr_s1, wr_s2, wr_s3;  // Write strobe, active low.
	logic [7:0] dat_s1, dat_s2;       // Data bus.
	logic       wr_edge;              // Rising edge of the write strobe.
	cmd_state_t state;                // Command decoder state.
	logic [7:0] div_param;            // First parameter byte.
	logic [7:0] rtn_param;            // Second parameter byte.
	logic       base_tick;            // Oscillator divided by the prescaler.
	logic       idle_active;          // Idle mode under MCU operation.
	logic       div_active;           // Halving selected and applied.
	logic       half_phase;           // Alternates on each base tick while halving, else cleared on the next base tick.
	logic       clk_tick;             // Divided internal clock tick.
	logic [RTN_W-1:0]   line_len;     // Clocks per line in force.
	logic [RTN_W-1:0]   clk_cnt;      // Clocks counted in this line.
	logic [TOTAL_W-1:0] total_lines;  // Lines per frame.
	logic               line_end;     // Last clock of a line.

	// Passes every pin through two flip-flops before any logic reads it.
	always_ff @(posedge mclk) begin
		if (rst) begin
			dcx_s1 <= 1'b1;
			dcx_s2 <= 1'b1;
			rd_s1  <= 1'b1;
			rd_s2  <= 1'b1;
			wr_s1  <= 1'b1;
			wr_s2  <= 1'b1;
			wr_s3  <= 1'b1;
			dat_s1 <= 8'h00;
			dat_s2 <= 8'h00;
		end else if (ce) begin
			dcx_s1 <= data_command_select;
			dcx_s2 <= dcx_s1;
			rd_s1  <= read_strobe_n;
			rd_s2  <= rd_s1;
			wr_s1  <= write_strobe_n;
			wr_s2  <= wr_s1;
			wr_s3  <= wr_s2;
			dat_s1 <= mcu_data;
			dat_s2 <= dat_s1;
		end
	end

	// A write is latched on the strobe's rising edge with read idle.
	assign wr_edge = ce && wr_s2 && !wr_s3 && rd_s2;

	// Decodes the command and steps through its two parameter bytes.
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_WAIT_CMD;
		end else if (wr_edge) begin
			if (!dcx_s2) begin
				// Any command byte restarts decoding.
				if (dat_s2 == IDLE_FRAME_RATE_CMD) begin
					state <= ST_PARAM1;
				end else begin
					state <= ST_WAIT_CMD;
				end
			end else begin
				case (state)
					ST_PARAM1: state <= ST_PARAM2;
					ST_PARAM2: state <= ST_WAIT_CMD;
					default:   state <= ST_WAIT_CMD;
				endcase
			end
		end
	end

	// Stores the parameter bytes; unused upper bits are kept as written.
	always_ff @(posedge mclk) begin
		if (rst) begin
			div_param <= DIV_PARAM_RESET;
			rtn_param <= RTN_PARAM_RESET;
		end else if (wr_edge && dcx_s2) begin
			if (state == ST_PARAM1) begin
				div_param <= dat_s2;
			end else if (state == ST_PARAM2) begin
				rtn_param <= dat_s2;
			end
		end
	end

	// Produces the base clock from the oscillator.
	osc_prescaler #(
		.RATIO (OSC_PRESCALE)
	) u_prescaler (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.tick (base_tick)
	);

	// The idle settings act only in idle mode under MCU operation.
	assign idle_active = idle_mode && mcu_mode;
	assign div_active  = idle_active &&
		(div_param[DIV_LSB +: DIV_W] == DIV_CODE_HALF);
	// Every base tick passes when undivided, every second when halved.
	assign clk_tick    = ce && base_tick && (!div_active || half_phase);
	// Idle mode under MCU operation takes clocks per line straight from the field.
	assign line_len    = idle_active ? rtn_param[RTN_LSB +: RTN_W]
	                                 : normal_line_period;
	assign total_lines = TOTAL_W'(driven_lines) + TOTAL_W'(back_porch)
	                   + TOTAL_W'(front_porch);
	assign line_end    = clk_tick && (clk_cnt == line_len - 1'b1);

	// Alternates the halving phase so that one base tick in two passes.
	always_ff @(posedge mclk) begin
		if (rst) begin
			half_phase <= 1'b0;
		end else if (ce && base_tick) begin
			half_phase <= div_active ? !half_phase : 1'b0;
		end
	end

	// Counts divided clocks within a line and marks the line end.
	always_ff @(posedge mclk) begin
		if (rst) begin
			clk_cnt    <= '0;
			line_pulse <= 1'b0;
		end else if (ce) begin
			line_pulse <= line_end;
			if (line_end) begin
				clk_cnt <= '0;
			end else if (clk_tick) begin
				clk_cnt <= clk_cnt + 1'b1;
			end
		end
	end

	// Counts lines of the frame, porches included, and marks frame end.
	always_ff @(posedge mclk) begin
		if (rst) begin
			line_index  <= '0;
			frame_pulse <= 1'b0;
		end else if (ce) begin
			frame_pulse <= 1'b0;
			if (line_end) begin
				if (line_index >= total_lines - 1'b1) begin
					line_index  <= '0;
					frame_pulse <= 1'b1;
				end else begin
					line_index <= line_index + 1'b1;
				end
			end
		end
	end

	// Shows the stored settings, whether or not they are in force.
	always_ff @(posedge mclk) begin
		if (rst) begin
			idle_clock_divider <= DIV_PARAM_RESET[DIV_LSB +: DIV_W];
			idle_line_period   <= RTN_PARAM_RESET[RTN_LSB +: RTN_W];
		end else if (ce) begin
			idle_clock_divider <= div_param[DIV_LSB +: DIV_W];
			idle_line_period   <= rtn_param[RTN_LSB +: RTN_W];
		end
	end

	// A command byte of the right code opens parameter one.
	sequence s_cmd_write;
		wr_edge && !dcx_s2 && dat_s2 == IDLE_FRAME_RATE_CMD;
	endsequence
	property p_cmd_decode;
		@(posedge mclk) disable iff (rst) s_cmd_write |=> state == ST_PARAM1;
	endproperty
	a_cmd_decode: assert property (p_cmd_decode) else $error("command not decoded");

	// First parameter lands in the divider output two cycles later.
	sequence s_param1_write;
		wr_edge && dcx_s2 && state == ST_PARAM1;
	endsequence
	property p_div_store;
		@(posedge mclk) disable iff (rst)
		s_param1_write ##1 ce |=> idle_clock_divider == $past(dat_s2[1:0], 2);
	endproperty
	a_div_store: assert property (p_div_store) else $error("divider not stored");

	// Once halving passes a tick, the next base tick one period on is held back.
	sequence s_half_pass;
		clk_tick && div_active;
	endsequence
	property p_half_block;
		@(posedge mclk) disable iff (rst || !ce)
		s_half_pass ##26 (div_active && base_tick) |-> !clk_tick;
	endproperty
	a_half_block: assert property (p_half_block) else $error("halving leaked a tick");

	// Second parameter lands in the line period output.
	property p_rtn_store;
		@(posedge mclk) disable iff (rst)
		(wr_edge && dcx_s2 && state == ST_PARAM2) ##1 ce
		|=> idle_line_period == $past(dat_s2[4:0], 2);
	endproperty
	a_rtn_store: assert property (p_rtn_store) else $error("line period not stored");

	// A line ends on the clock that completes the line length.
	property p_line_end;
		@(posedge mclk) disable iff (rst)
		(clk_tick && clk_cnt == line_len - 1'b1) |=> line_pulse && clk_cnt == 0;
	endproperty
	a_line_end: assert property (p_line_end) else $error("line did not end");

	// Base ticks are never adjacent while enabled.
	property p_base_spacing;
		@(posedge mclk) disable iff (rst) (ce && base_tick) ##1 ce |-> !base_tick;
	endproperty
	a_base_spacing: assert property (p_base_spacing) else $error("base ticks too close");

	// The last line of a frame raises the frame pulse.
	property p_frame_end;
		@(posedge mclk) disable iff (rst)
		(line_end && line_index == total_lines - 1'b1) |=> frame_pulse && line_index == 0;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame did not end");

	// Undivided operation passes a tick again one prescale period later.
	property p_ratio_full;
		@(posedge mclk) disable iff (rst || !ce)
		(clk_tick && !div_active) ##26 !div_active |-> clk_tick;
	endproperty
	a_ratio_full: assert property (p_ratio_full) else $error("undivided tick lost");

	// Line counting runs through porches without an early frame pulse.
	property p_lines_counted;
		@(posedge mclk) disable iff (rst)
		(line_end && line_index < total_lines - 1'b1) |=> !frame_pulse;
	endproperty
	a_lines_counted: assert property (p_lines_counted) else $error("frame ended early");
endmodule

// *** rtl/idle_frame_rate_pkg.sv ***
// Constants shared by the idle-mode frame-rate block and its prescaler.
// Assumes a 100 MHz mclk that stands in for the internal oscillator.
package idle_frame_rate_pkg;
	// Clock period of mclk in nanoseconds.
	localparam int         MCLK_PERIOD_NS     = 10;
	// Command code of the idle frame-rate command.
	localparam logic [7:0] IDLE_FRAME_RATE_CMD = 8'hb2;
	// Field positions inside the two parameter bytes.
	localparam int         DIV_LSB            = 0;
	localparam int         DIV_W              = 2;
	localparam int         RTN_LSB            = 0;
	localparam int         RTN_W              = 5;
	// Reset values of the parameter bytes.
	localparam logic [7:0] DIV_PARAM_RESET    = 8'h00;
	localparam logic [7:0] RTN_PARAM_RESET    = 8'h1e;
	// Divider codes: undivided and halved.
	localparam logic [1:0] DIV_CODE_FULL      = 2'h0;
	localparam logic [1:0] DIV_CODE_HALF      = 2'h1;
	// Oscillator prescale ratio that yields the base clock.
	localparam int         OSC_PRESCALE       = 26;
	// Widths of the line counters.
	localparam int         LINE_W             = 9;
	localparam int         PORCH_W            = 7;
	localparam int         TOTAL_W            = 10;
	// Command decoder states, Gray coded from ST_WAIT_CMD to ST_PARAM2; the return to ST_WAIT_CMD flips two bits.
	typedef enum logic [1:0] {
		ST_WAIT_CMD = 2'b00,
		ST_PARAM1   = 2'b01,
		ST_PARAM2   = 2'b11
	} cmd_state_t;
endpackage

// *** rtl/osc_prescaler.sv ***
// Divides the oscillator clock into a one-cycle base tick.
// Assumes ce freezes the count and rst is synchronous, active high.
module osc_prescaler
	import idle_frame_rate_pkg::*;
#(
	parameter int RATIO = OSC_PRESCALE
) (
	// Clock, reset and enable.
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ce,
	// One-cycle base tick.
	output logic      tick
);
	localparam int CW = $clog2(RATIO);
	localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

	logic [CW-1:0] count; // Position within one prescale period.

	// Counts oscillator cycles and pulses tick in the cycle after the last of each period.
	always_ff @(posedge mclk) begin
		if (rst) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (ce) begin
			if (count == LAST) begin
				count <= '0;
				tick  <= 1'b1;
			end else begin
				count <= count + 1'b1;
				tick  <= 1'b0;
			end
		end
	end
endmodule

// *** sim/mcu_host_model.sv ***
// Host microcontroller model that drives the MCU write pins.
// Assumes the device samples the pins on mclk and needs 3+ cycles a phase.
module mcu_host_model (
	// Clock.
	input  wire logic       mclk,
	// MCU write pins.
	output logic            data_command_select,
	output logic            read_strobe_n,
	output logic            write_strobe_n,
	output logic [7:0]      mcu_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins idle with both strobes high.
	initial begin
		data_command_select = 1'b1;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		mcu_data = 8'h00;
	end

	// One byte: strobe low four cycles, high four, then the bus floats.
	task automatic put(input logic dcx, input logic rd_n, input logic [7:0] d);
		@(posedge mclk);
		data_command_select <= dcx;
		read_strobe_n <= rd_n;
		mcu_data <= d;
		write_strobe_n <= 1'b0;
		repeat (4) @(posedge mclk);
		write_strobe_n <= 1'b1;
		repeat (4) @(posedge mclk);
		// A floating bus must not keep showing the last byte.
		mcu_data <= ~d;
		read_strobe_n <= 1'b1;
	endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the idle frame-rate block.
// Assumes a 100 MHz mclk and the host model on the MCU pins.
module tb_top;
	import idle_frame_rate_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic                mclk = 1'b0;
	logic                rst = 1'b1;
	logic                idle_mode = 1'b0;
	logic                mcu_mode = 1'b1;
	logic [RTN_W-1:0]    normal_line_period = 5'h14;
	logic [LINE_W-1:0]   driven_lines = 9'h001;
	logic [PORCH_W-1:0]  back_porch = 7'h01;
	logic [PORCH_W-1:0]  front_porch = 7'h01;
	logic                data_command_select;
	logic                read_strobe_n;
	logic                write_strobe_n;
	logic [7:0]          mcu_data;
	logic [DIV_W-1:0]    idle_clock_divider;
	logic [RTN_W-1:0]    idle_line_period;
	logic                line_pulse;
	logic                frame_pulse;
	logic [TOTAL_W-1:0]  line_index;
	logic [8:0]          notes[$];
	logic [8:0]          note;
	logic [1:0]          sh_div = 2'h0;
	logic [4:0]          sh_rtn = 5'h1e;
	logic [1:0]          last_div;
	logic [4:0]          last_rtn;
	logic [31:0]         seed = 32'h59;
	logic [4:0]          r1;
	int                  n_fail = 0;
	int                  comparisons = 0;

	always #5 mclk = ~mclk;

	mcu_host_model host (.mclk(mclk), .data_command_select(data_command_select),
		.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .mcu_data(mcu_data));

	idle_frame_rate_control DUT (.mclk(mclk), .rst(rst), .ce(1'b1),
		.data_command_select(data_command_select), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .mcu_data(mcu_data), .idle_mode(idle_mode),
		.mcu_mode(mcu_mode), .normal_line_period(normal_line_period),
		.driven_lines(driven_lines), .back_porch(back_porch), .front_porch(front_porch),
		.idle_clock_divider(idle_clock_divider), .idle_line_period(idle_line_period),
		.line_pulse(line_pulse), .frame_pulse(frame_pulse), .line_index(line_index));

	// Xorshift generator seeded with 89.
	function logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Compares a stored setting byte.
	task automatic check_field(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Compares a cycle count.
	task automatic check_count(input string nm, input int e, input int g);
		comparisons++;
		if (g != e) begin
			n_fail++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	// Cycles until the next line pulse (sel 0) or frame pulse (sel 1).
	task automatic count_to(input logic sel, output int k);
		k = 0;
		do begin
			@(posedge mclk);
			#1;
			k++;
		end while ((sel ? frame_pulse : line_pulse) !== 1'b1 && k < 20000);
		if (k >= 20000) begin
			check_count("pulse_wait", 0, k);
			tally_and_finish();
		end
	endtask

	// Measures one line and one whole frame against the expected rate.
	task automatic measure(input int ratio, input int len);
		int lines;
		int k;
		lines = driven_lines + back_porch + front_porch;
		count_to(1'b1, k);
		count_to(1'b0, k);
		check_count("line_cycles", OSC_PRESCALE * ratio * len, k);
		count_to(1'b1, k);
		count_to(1'b1, k);
		check_count("frame_cycles", OSC_PRESCALE * ratio * len * lines, k);
	endtask

	// Sends command and both parameters, noting the changes expected.
	task automatic set_rate(input logic [1:0] dv, input logic [4:0] rt);
		if (dv !== sh_div) notes.push_back({1'b0, 6'h00, dv});
		if (rt !== sh_rtn) notes.push_back({1'b1, 3'h0, rt});
		sh_div = dv;
		sh_rtn = rt;
		host.put(1'b0, 1'b1, IDLE_FRAME_RATE_CMD);
		host.put(1'b1, 1'b1, {6'h00, dv});
		host.put(1'b1, 1'b1, {3'h0, rt});
		repeat (8) @(posedge mclk);
	endtask

	// Watches the settings and checks each change against the oldest note.
	always @(posedge mclk) begin
		if (!rst && (idle_clock_divider !== last_div || idle_line_period !== last_rtn)) begin
			if (notes.size() == 0) begin
				check_count("unexpected_change", 0, 1);
			end else begin
				note = notes.pop_front();
				if (note[8]) check_field("idle_line_period", note[7:0], {3'h0, idle_line_period});
				else check_field("idle_clock_divider", note[7:0], {6'h00, idle_clock_divider});
			end
		end
		last_div <= idle_clock_divider;
		last_rtn <= idle_line_period;
	end

	// Main sequence.
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		driven_lines <= 9'h001 + 9'(next_rand() % 2);
		normal_line_period <= 5'h10 + 5'(next_rand() % 16);
		r1 = 5'h10 + 5'(next_rand() % 14);
		@(posedge mclk);
		#1;
		check_field("idle_clock_divider", DIV_PARAM_RESET, {6'h00, idle_clock_divider});
		check_field("idle_line_period", RTN_PARAM_RESET, {3'h0, idle_line_period});
		@(posedge mclk);
		idle_mode <= 1'b1;
		set_rate(DIV_CODE_HALF, r1);
		measure(2, r1);
		// Refused bytes: orphan parameter, foreign command, write with read low.
		host.put(1'b1, 1'b1, 8'h02);
		host.put(1'b0, 1'b1, 8'h36);
		host.put(1'b1, 1'b1, 8'h00);
		host.put(1'b0, 1'b0, IDLE_FRAME_RATE_CMD);
		host.put(1'b1, 1'b1, 8'h00);
		set_rate(DIV_CODE_FULL, r1 + 5'h01);
		measure(1, r1 + 5'h01);
		@(posedge mclk);
		idle_mode <= 1'b0;
		measure(1, normal_line_period);
		@(posedge mclk);
		idle_mode <= 1'b1;
		mcu_mode <= 1'b0;
		set_rate(DIV_CODE_HALF, r1 + 5'h01);
		measure(1, normal_line_period);
		check_count("pending_notes", 0, notes.size());
		tally_and_finish();
	end
endmodule
